// ### core/ebcs_device.sv
// encoder end: burst, subcarrier word, line-21 bytes and two sync pins
// assumes the far end drives register strobes on i_mclk and may drive pins
//
// What this block does
// - burst amplitude resets to 47
// - host writes 63 for NTSC 92.5 IRE
// - host writes 45 for PAL 92.5 IRE
// - host writes 67 for NTSC 100 IRE
// - subcarrier word held in four byte registers
// - highest subaddress byte is most significant
// - four caption and extended-data byte registers
// - line-21 bytes sent least significant bit first
// - host supplies parity in each byte msb
// - second pin polarity: 0 high/rising, 1 low/falling
// - second pin direction: 0 input, 1 output
// - blanking bit 0 drives horizontal reference pulse
// - blanking bit 1 drives blanking pulse, vertical suppressed
// - input pin two: hsync only or also blanking
// - first pin polarity: 0 high/rising, 1 low/falling
// - first pin direction: 0 input, 1 output
// - source 0: first pin or embedded codes
// - source 1: horizontal sync from second pin or embedded codes
// - two-bit field selects first pin signal type
// - type 00 vsync, 01 frame, 10 sequence
`timescale 1ns/10ps
module ebcs_device
    import ebcs_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    ebcs_if.dev bus,
    input wire logic i_line_start,
    input wire logic i_in_ref_window,
    input wire logic i_in_active_lines,
    input wire logic i_field_odd,
    input wire logic i_vsync_each,
    input wire logic i_frame_sync,
    input wire logic i_field_seq,
    input wire logic i_embedded_hsync,
    input wire logic i_embedded_sync_select,
    input wire logic i_line21_start,
    input wire logic i_bit_tick,
    output logic [7:0] o_burst_amplitude,
    output logic [31:0] o_subcarrier_phase,
    output logic o_caption_bit,
    output logic o_caption_valid,
    output logic o_hsync,
    output logic o_int_blank,
    output logic o_first_pin_event
);
    logic [7:0] burst_q;
    logic [7:0] scw_q [4];
    logic [7:0] l21_q [4];
    logic [7:0] sync_q;
    logic [7:0] rdata_q;
    logic [31:0] phase_q;
    logic [15:0] shift_q;
    logic [4:0] bitcnt_q;
    logic busy_q;
    logic p1_o_q;
    logic p1_oe_q;
    logic p2_o_q;
    logic p2_oe_q;
    logic hsync_q;
    logic blank_q;
    logic ev1_q;
    logic p1_lvl;
    logic p1_edge;
    logic p2_lvl;
    logic p2_edge;
    logic [31:0] scw_word;
    logic type_pulse;
    logic ref_pulse;

    // ----------------------------------------------------------------
    // register bank
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // byte writes; unmapped subaddresses ignored
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            burst_q <= BURST_RESET;
            sync_q <= SYNC_RESET;
            for (int i = 0; i < 4; i++) begin
                scw_q[i] <= SCW_RESET[8*i +: 8];
                l21_q[i] <= L21_RESET;
            end
        end else if (bus.wr) begin
            if (bus.addr == SA_BURST) begin
                burst_q <= bus.wdata;
            end
            if (in_range(bus.addr, SA_SCW_LO, SA_SCW_HI)) begin
                scw_q[2'(bus.addr - SA_SCW_LO)] <= bus.wdata;
            end
            if (in_range(bus.addr, SA_CAP_LO, SA_CAP_HI)) begin
                l21_q[2'(bus.addr - SA_CAP_LO)] <= bus.wdata;
            end
            if (bus.addr == SA_SYNC) begin
                sync_q <= bus.wdata;
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            if (bus.addr == SA_BURST) begin
                rdata_q <= burst_q;
            end else if (in_range(bus.addr, SA_SCW_LO, SA_SCW_HI)) begin
                rdata_q <= scw_q[2'(bus.addr - SA_SCW_LO)];
            end else if (in_range(bus.addr, SA_CAP_LO, SA_CAP_HI)) begin
                rdata_q <= l21_q[2'(bus.addr - SA_CAP_LO)];
            end else if (bus.addr == SA_SYNC) begin
                rdata_q <= sync_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign bus.rdata = rdata_q;

    // ----------------------------------------------------------------
    // subcarrier generator
    // ----------------------------------------------------------------
    assign scw_word = {scw_q[3], scw_q[2], scw_q[1], scw_q[0]};

    // modulo 2^32 wrap comes free from the 32-bit add
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            phase_q <= 32'h0000_0000;
        end else begin
            phase_q <= phase_q + scw_word;
        end
    end

    // ----------------------------------------------------------------
    // line-21 serialiser
    // ----------------------------------------------------------------
    // bytes sampled at insertion start so a mid-line write waits a line
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            shift_q <= 16'h0000;
            bitcnt_q <= 5'h00;
            busy_q <= 1'b0;
        end else if (i_line21_start) begin
            shift_q <= i_field_odd ? {l21_q[1], l21_q[0]} : {l21_q[3], l21_q[2]};
            bitcnt_q <= 5'h00;
            busy_q <= 1'b1;
        end else if (busy_q && i_bit_tick) begin
            shift_q <= {1'b0, shift_q[15:1]};
            bitcnt_q <= bitcnt_q + 5'h01;
            if (bitcnt_q == {L21_LAST, 1'b1}) begin
                busy_q <= 1'b0;
            end
        end
    end
    assign o_caption_bit = shift_q[0];
    assign o_caption_valid = busy_q;

    // ----------------------------------------------------------------
    // sync pins
    // ----------------------------------------------------------------
    ebcs_sync3 u_sync1 (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async(bus.pin1_lvl),
        .i_falling(sync_q[B_POL1]),
        .o_level(p1_lvl),
        .o_edge(p1_edge)
    );
    ebcs_sync3 u_sync2 (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async(bus.pin2_lvl),
        .i_falling(sync_q[B_POL2]),
        .o_level(p2_lvl),
        .o_edge(p2_edge)
    );

    // first pin carries the selected type either way
    always_comb begin
        case (ebcs_type_t'(sync_q[B_TYPE_HI:B_TYPE_LO]))
            TYPE_VSYNC: type_pulse = i_vsync_each;
            TYPE_FRAME: type_pulse = i_frame_sync;
            TYPE_SEQ: type_pulse = i_field_seq;
            default: type_pulse = 1'b0;
        endcase
    end

    // second pin pulse; blanking variant drops outside active lines
    assign ref_pulse = i_in_ref_window & (~sync_q[B_BLNK] | i_in_active_lines);

    // pin drivers, polarity applied on output
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            p1_o_q <= 1'b0;
            p1_oe_q <= 1'b0;
            p2_o_q <= 1'b0;
            p2_oe_q <= 1'b0;
        end else begin
            p1_oe_q <= sync_q[B_DIR1];
            p1_o_q <= type_pulse ^ sync_q[B_POL1];
            p2_oe_q <= sync_q[B_DIR2];
            p2_o_q <= ref_pulse ^ sync_q[B_POL2];
        end
    end
    assign bus.pin1_dev_o = p1_o_q;
    assign bus.pin1_dev_oe = p1_oe_q;
    assign bus.pin2_dev_o = p2_o_q;
    assign bus.pin2_dev_oe = p2_oe_q;

    // horizontal sync source and input blanking
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            hsync_q <= 1'b0;
            blank_q <= 1'b0;
            ev1_q <= 1'b0;
        end else begin
            ev1_q <= ~sync_q[B_DIR1] & p1_edge;
            if (i_embedded_sync_select) begin
                hsync_q <= i_embedded_hsync;
            end else if (sync_q[B_HSRC]) begin
                hsync_q <= ~sync_q[B_DIR2] & p2_edge;
            end else begin
                hsync_q <= ~sync_q[B_DIR1] & p1_edge;
            end
            // active level of pin two marks active video when used as blanking
            blank_q <= ~sync_q[B_DIR2] & ~i_embedded_sync_select & sync_q[B_BLNK]
                       & (p2_lvl == sync_q[B_POL2]);
        end
    end
    assign o_hsync = hsync_q;
    assign o_int_blank = blank_q;
    assign o_first_pin_event = ev1_q;

    // line start is accepted but only shapes the window externally
    logic unused_ok;
    assign unused_ok = i_line_start & p1_lvl;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_burst_amplitude <= BURST_RESET;
            o_subcarrier_phase <= 32'h0000_0000;
        end else begin
            o_burst_amplitude <= burst_q;
            o_subcarrier_phase <= phase_q;
        end
    end
endmodule : ebcs_device

// ### core/ebcs_pkg.sv
// package for the encoder burst/caption/sync register bank
// assumes byte-wide subaddressed register access over the ebcs interface
package ebcs_pkg;
    // subaddresses
    localparam logic [7:0] SA_BURST = 8'h62;
    localparam logic [7:0] SA_SCW_LO = 8'h63;
    localparam logic [7:0] SA_SCW_HI = 8'h66;
    localparam logic [7:0] SA_CAP_LO = 8'h67;
    localparam logic [7:0] SA_CAP_HI = 8'h6a;
    localparam logic [7:0] SA_SYNC = 8'h6b;
    // burst amplitude values
    localparam logic [7:0] BURST_RESET = 8'h2f;
    localparam logic [7:0] BURST_NTSC_925 = 8'h3f;
    localparam logic [7:0] BURST_PAL_925 = 8'h2d;
    localparam logic [7:0] BURST_NTSC_100 = 8'h43;
    // subcarrier word reset (arbitrary neutral default)
    localparam logic [31:0] SCW_RESET = 32'h0000_0000;
    localparam logic [7:0] L21_RESET = 8'h00;
    localparam logic [7:0] SYNC_RESET = 8'h00;
    // sync pin control field positions
    localparam int B_POL2 = 7;
    localparam int B_DIR2 = 6;
    localparam int B_BLNK = 5;
    localparam int B_POL1 = 4;
    localparam int B_DIR1 = 3;
    localparam int B_HSRC = 2;
    localparam int B_TYPE_HI = 1;
    localparam int B_TYPE_LO = 0;
    // first sync pin signal types
    typedef enum logic [1:0] {
        TYPE_VSYNC = 2'h0,
        TYPE_FRAME = 2'h1,
        TYPE_SEQ = 2'h2,
        TYPE_NA = 2'h3
    } ebcs_type_t;
    // line-21 serial byte length
    localparam logic [3:0] L21_BITS = 4'h8;
    localparam logic [3:0] L21_LAST = 4'h7;
endpackage : ebcs_pkg

// ### core/ebcs_if.sv
// interface joining the encoder register bank and its host/sync partner
// assumes both parties share i_mclk; pins are split into in/out/enable
`timescale 1ns/10ps
interface ebcs_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic pin1_dev_o;
    logic pin1_dev_oe;
    logic pin1_far_o;
    logic pin1_far_oe;
    logic pin2_dev_o;
    logic pin2_dev_oe;
    logic pin2_far_o;
    logic pin2_far_oe;
    logic pin1_lvl;
    logic pin2_lvl;
    // wire level resolves from the enables, device driver first
    assign pin1_lvl = pin1_dev_oe ? pin1_dev_o : (pin1_far_oe ? pin1_far_o : 1'b0);
    assign pin2_lvl = pin2_dev_oe ? pin2_dev_o : (pin2_far_oe ? pin2_far_o : 1'b0);
    modport dev (input addr, input wdata, input wr, input rd, output rdata,
                 output pin1_dev_o, output pin1_dev_oe, output pin2_dev_o, output pin2_dev_oe,
                 input pin1_lvl, input pin2_lvl);
    modport far (output addr, output wdata, output wr, output rd, input rdata,
                 output pin1_far_o, output pin1_far_oe, output pin2_far_o, output pin2_far_oe,
                 input pin1_lvl, input pin2_lvl);
endinterface : ebcs_if

// ### core/ebcs_sync3.sv
// three-stage synchroniser with agreement-based edge detect
// assumes an asynchronous level input and one clock
`timescale 1ns/10ps
module ebcs_sync3 (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_async,
    input wire logic i_falling,
    output logic o_level,
    output logic o_edge
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic edge_q;
    // first stage is read only by the second
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // a change counts once stages two and three agree
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            lvl_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            edge_q <= 1'b0;
            if (s2_q == s3_q && s3_q != lvl_q) begin
                lvl_q <= s3_q;
                edge_q <= (s3_q != i_falling);
            end
        end
    end
    assign o_level = lvl_q;
    assign o_edge = edge_q;
endmodule : ebcs_sync3

// ### core/ebcs_far.sv
// partner end: register master and sync source for the encoder
// assumes a plain user command port on i_mclk
`timescale 1ns/10ps
module ebcs_far
    import ebcs_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    ebcs_if.far bus,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_pin1_drive,
    input wire logic i_pin1_value,
    input wire logic i_pin2_drive,
    input wire logic i_pin2_value,
    output logic [7:0] o_rdata,
    output logic o_rvalid
);
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic wr_q;
    logic rd_q;
    logic rd_wait_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic p1o_q;
    logic p1e_q;
    logic p2o_q;
    logic p2e_q;

    // ----------------------------------------------------------------
    // command forwarding
    // ----------------------------------------------------------------
    // caption bytes must carry parity in bit 7: user supplies it
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            addr_q <= i_addr;
            wdata_q <= i_wdata;
            wr_q <= i_wr & ~i_rd;
            rd_q <= i_rd;
        end
    end
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;

    // read data arrives the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rd_wait_q <= 1'b0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rd_wait_q <= rd_q;
            rvalid_q <= rd_wait_q;
            if (rd_wait_q) begin
                rdata_q <= bus.rdata;
            end
        end
    end
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;

    // pin drive for input-configured encoder pins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            p1o_q <= 1'b0;
            p1e_q <= 1'b0;
            p2o_q <= 1'b0;
            p2e_q <= 1'b0;
        end else begin
            p1o_q <= i_pin1_value;
            p1e_q <= i_pin1_drive;
            p2o_q <= i_pin2_value;
            p2e_q <= i_pin2_drive;
        end
    end
    assign bus.pin1_far_o = p1o_q;
    assign bus.pin1_far_oe = p1e_q;
    assign bus.pin2_far_o = p2o_q;
    assign bus.pin2_far_oe = p2e_q;
endmodule : ebcs_far

// ### sim/ebcs_asserts.sv
// checker for the ebcs register port and sync pin enables
// assumes the interface signals are wired in by name
`timescale 1ns/10ps
module ebcs_asserts
    import ebcs_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic pin1_dev_o,
    input wire logic pin1_dev_oe,
    input wire logic pin2_dev_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // ----
    // shadow of the bank
    // ----
    logic [7:0] sh_q [SA_BURST:SA_SYNC];
    logic [7:0] exp_q;
    logic [7:0] ctl;
    logic [1:0] age_q;
    logic hit;
    assign hit = addr >= SA_BURST && addr <= SA_SYNC;
    assign ctl = sh_q[SA_SYNC];
    // writes land at the strobe edge
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int i = SA_BURST; i <= SA_SYNC; i++) begin
                sh_q[i] <= (i == SA_BURST) ? BURST_RESET : 8'h00;
            end
        end else if (wr && hit) begin
            sh_q[addr] <= wdata;
        end
    end
    // byte a read must return, taken at its strobe
    always_ff @(posedge i_mclk) begin
        exp_q <= hit ? sh_q[addr] : 8'h00;
    end
    // pins judged only after a control write settles
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || (wr && addr == SA_SYNC)) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    // ----
    // properties
    // ----
    property p_burst_rd;
        rd && addr == SA_BURST |=> rdata == exp_q;
    endproperty
    a_burst_rd: assert property (p_burst_rd) else $error("burst read-back wrong");
    property p_scw_rd;
        rd && addr >= SA_SCW_LO && addr <= SA_SCW_HI |=> rdata == exp_q;
    endproperty
    a_scw_rd: assert property (p_scw_rd) else $error("subcarrier byte wrong");
    property p_l21_rd;
        rd && addr >= SA_CAP_LO && addr <= SA_CAP_HI |=> rdata == exp_q;
    endproperty
    a_l21_rd: assert property (p_l21_rd) else $error("caption byte wrong");
    property p_ctl_rd;
        rd && addr == SA_SYNC |=> rdata == exp_q;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("sync control wrong");
    property p_dir2;
        age_q == 2'h3 |-> pin2_dev_oe == ctl[B_DIR2];
    endproperty
    a_dir2: assert property (p_dir2) else $error("pin two direction wrong");
    property p_dir1;
        age_q == 2'h3 |-> pin1_dev_oe == ctl[B_DIR1];
    endproperty
    a_dir1: assert property (p_dir1) else $error("pin one direction wrong");
    property p_na;
        age_q == 2'h3 && ctl[B_DIR1] && !ctl[B_POL1] && ctl[1:0] == 2'h3 |-> !pin1_dev_o;
    endproperty
    a_na: assert property (p_na) else $error("unused type not low");
    property p_rst;
        $fell(i_sys_rst) |-> (!pin1_dev_oe && !pin2_dev_oe && rdata == 8'h00) [*2];
    endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    c_burst: cover property (rd && addr == SA_BURST);
    c_pin2: cover property (pin2_dev_oe);
    c_field_sequence_sync: cover property (pin1_dev_oe && ctl[1:0] == 2'h2);
endmodule : ebcs_asserts

// ### sim/tb_top.sv
// self-checking bench: far end and device joined by ebcs_if
// assumes a 25 MHz clock and a synchronous active-high reset
`timescale 1ns/10ps
module tb_top
    import ebcs_pkg::*;
;
    // ----
    // signals and instances
    // ----
    logic i_mclk = 1'h0, i_sys_rst = 1'h1;
    logic [7:0] u_addr = 8'h00, u_wdata = 8'h00;
    logic u_wr = 1'h0, u_rd = 1'h0, p1d = 1'h0, p1v = 1'h0, p2d = 1'h0, p2v = 1'h0;
    logic win = 1'h0, act = 1'h0, odd = 1'h0, vsy = 1'h0, fr = 1'h0, fsq = 1'h0;
    logic ehs = 1'h0, esel = 1'h0, l21s = 1'h0, tick = 1'h0;
    logic [7:0] rdata, burst;
    logic [31:0] phase, p0;
    logic rvalid, cbit, cval, hs, blank, ev, lv;
    int fails = 0, n_compared = 0, cyc = 0, nh, ne;
    localparam logic [31:0] W = 32'h21f07c1f;
    logic [7:0] bv [3] = '{BURST_NTSC_925, BURST_PAL_925, BURST_NTSC_100};
    logic [7:0] lb [4] = '{8'hc1, 8'h52, 8'h8f, 8'h2a}; // odd parity held in bit 7
    // ctrl, window, active, vs/frame/seq, pin two select, expected level
    logic [14:0] pt [15] = '{{8'h40, 7'h43}, {8'h40, 7'h22}, {8'hc0, 7'h42},
        {8'h60, 7'h42}, {8'h60, 7'h63}, {8'he0, 7'h62},
        {8'h08, 7'h11}, {8'h08, 7'h0c}, {8'h09, 7'h09}, {8'h09, 7'h14},
        {8'h0a, 7'h05}, {8'h0a, 7'h18}, {8'h0b, 7'h1c}, {8'h18, 7'h10}, {8'h18, 7'h01}};
    // ctrl, pin two select, from, to, hsync, pin one event, blanking
    logic [13:0] it [8] = '{{8'h00, 6'h0e}, {8'h00, 6'h10}, {8'h10, 6'h16}, {8'h04, 6'h2c},
        {8'h04, 6'h0a}, {8'h24, 6'h31}, {8'h84, 6'h34}, {8'ha4, 6'h29}};
    ebcs_if i_ebcs_if ();
    ebcs_device i_ebcs_device (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(i_ebcs_if),
        .i_line_start(1'h0), .i_in_ref_window(win), .i_in_active_lines(act), .i_field_odd(odd),
        .i_vsync_each(vsy), .i_frame_sync(fr), .i_field_seq(fsq), .i_embedded_hsync(ehs),
        .i_embedded_sync_select(esel), .i_line21_start(l21s), .i_bit_tick(tick),
        .o_burst_amplitude(burst), .o_subcarrier_phase(phase), .o_caption_bit(cbit),
        .o_caption_valid(cval), .o_hsync(hs), .o_int_blank(blank), .o_first_pin_event(ev));
    ebcs_far i_ebcs_far (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(i_ebcs_if),
        .i_addr(u_addr), .i_wdata(u_wdata), .i_wr(u_wr), .i_rd(u_rd), .i_pin1_drive(p1d),
        .i_pin1_value(p1v), .i_pin2_drive(p2d), .i_pin2_value(p2v), .o_rdata(rdata), .o_rvalid(rvalid));
    ebcs_asserts i_ebcs_asserts (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .addr(i_ebcs_if.addr),
        .wdata(i_ebcs_if.wdata), .wr(i_ebcs_if.wr), .rd(i_ebcs_if.rd), .rdata(i_ebcs_if.rdata),
        .pin1_dev_o(i_ebcs_if.pin1_dev_o), .pin1_dev_oe(i_ebcs_if.pin1_dev_oe),
        .pin2_dev_oe(i_ebcs_if.pin2_dev_oe));
    // free-running clock
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end
    // hang guard, far above the run length
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    // ----
    // tasks
    // ----
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        u_addr <= a;
        u_wdata <= d;
        u_wr <= 1'h1;
        @(posedge i_mclk);
        u_wr <= 1'h0;
    endtask : wreg
    // far end returns the byte a few cycles on; wait bounded
    task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge i_mclk);
        u_addr <= a;
        u_rd <= 1'h1;
        @(posedge i_mclk);
        u_rd <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_mclk);
            #1;
            if (rvalid === 1'h1) break;
        end
        chk(nm, {1'h1, e}, {rvalid, rdata});
    endtask : rreg
    task automatic setc(input logic [7:0] c);
        wreg(SA_SYNC, c);
        repeat (4) @(posedge i_mclk);
    endtask : setc
    // one insertion: sixteen bits, one per tick
    task automatic ins(input logic o, input logic [15:0] e);
        @(posedge i_mclk);
        odd <= o;
        l21s <= 1'h1;
        @(posedge i_mclk);
        l21s <= 1'h0;
        for (int i = 0; i < 16; i++) begin
            #1;
            chk("l21_bit", {1'h1, e[i]}, {cval, cbit});
            @(posedge i_mclk);
            tick <= 1'h1;
            @(posedge i_mclk);
            tick <= 1'h0;
        end
        #1;
        chk("l21_end", 1'h0, cval);
    endtask : ins
    // counts sync pulses over the next twelve cycles; x never counts
    task automatic cnt();
        nh = 0;
        ne = 0;
        repeat (12) begin
            #1;
            nh += (hs === 1'h1);
            ne += (ev === 1'h1);
            @(posedge i_mclk);
        end
    endtask : cnt
    task automatic ptest(input logic [13:0] t);
        setc(t[13:6]);
        if (t[5]) begin
            p2v <= t[4];
            repeat (8) @(posedge i_mclk);
            p2v <= t[3];
        end else begin
            p1v <= t[4];
            repeat (8) @(posedge i_mclk);
            p1v <= t[3];
        end
        cnt();
        chk("hsync", t[2], nh);
        chk("pin1_event", t[1], ne);
        chk("int_blank", t[0], blank);
    endtask : ptest
    // ----
    // main sequence
    // ----
    initial begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'h0;
        rreg(SA_BURST, BURST_RESET, "burst");
        chk("burst_out", BURST_RESET, burst);
        rreg(SA_SYNC, SYNC_RESET, "sync_ctrl");
        chk("pin_oe", 2'h0, {i_ebcs_if.pin1_dev_oe, i_ebcs_if.pin2_dev_oe});
        rreg(8'h70, 8'h00, "unmapped");
        foreach (bv[i]) begin
            wreg(SA_BURST, bv[i]);
            rreg(SA_BURST, bv[i], "burst");
            chk("burst_out", bv[i], burst);
        end
        for (int i = 0; i < 4; i++) begin
            wreg(8'(SA_SCW_LO + i), W[8*i +: 8]);
            rreg(8'(SA_SCW_LO + i), W[8*i +: 8], "scw_byte");
        end
        // seven steps wrap past the top of the accumulator
        @(posedge i_mclk);
        #1;
        p0 = phase;
        repeat (7) @(posedge i_mclk);
        #1;
        chk("phase_step", W * 32'h7, phase - p0);
        for (int i = 0; i < 4; i++) begin
            wreg(8'(SA_CAP_LO + i), lb[i]);
        end
        rreg(SA_CAP_HI, lb[3], "l21_byte");
        ins(1'h1, {lb[1], lb[0]});
        ins(1'h0, {lb[3], lb[2]});
        ins(1'h1, {lb[1], lb[0]});
        wreg(SA_CAP_LO, 8'h0e);
        ins(1'h1, {lb[1], 8'h0e});
        foreach (pt[i]) begin
            setc(pt[i][14:7]);
            {win, act, vsy, fr, fsq} <= pt[i][6:2];
            repeat (3) @(posedge i_mclk);
            #1;
            lv = pt[i][1] ? i_ebcs_if.pin2_lvl : i_ebcs_if.pin1_lvl;
            chk("pin_out", pt[i][0], lv);
        end
        setc(8'h00);
        p1d <= 1'h1;
        p2d <= 1'h1;
        foreach (it[i]) begin
            ptest(it[i]);
        end
        esel <= 1'h1;
        @(posedge i_mclk);
        ehs <= 1'h1;
        @(posedge i_mclk);
        ehs <= 1'h0;
        cnt();
        chk("emb_hsync", 32'h1, nh);
        conclude();
    end
endmodule : tb_top
